// ==== rtl/mps_handler_out.v ====
// handler port output logic for multi-parameter sorting
// assumes the analog engine runs on ref_clk and pulses adc_done once per
// start, with the four parameter values valid in that same cycle
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "mps_regs.vh"

// Behaviour
// [RULE1] fail line asserts when any compared parameter is out of limits
// [RULE2] conversion-done strobe asserts as soon as the conversion ends
// [RULE3] measurement-done strobe asserts only after the whole cycle ends
// [RULE4] sort port behaves as clear, hold or pulse by configuration
// [RULE5] aux enabled and only secondary fails: aux bin, no fail line
// [RULE6] deviation mode compares against stored nominal, which must be set
// [RULE7] one active-low out-of-limit line per each of four parameters
// [RULE8] results only valid once measurement-done strobe is asserted
// [RULE9] about 4.5 ms compare time after conversion before results final
module mps_handler_out #(
	parameter COMPARE_CYCLES = `MPS_COMPARE_CYCLES,
	parameter PULSE_UNIT_CYCLES = `MPS_PULSE_UNIT_CYCLES
) (
	input wire ref_clk,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire handler_trigger_n,
	output reg meas_start,
	input wire adc_done,
	input wire [31:0] param_one_value,
	input wire [31:0] param_two_value,
	input wire [31:0] param_three_value,
	input wire [31:0] param_four_value,
	output reg param_one_fail_n,
	output reg param_two_fail_n,
	output reg param_three_fail_n,
	output reg param_four_fail_n,
	output reg fail_n,
	output reg aux_bin_n,
	output reg conversion_done_n,
	output reg measurement_done_n,
	output reg irq
);

	// ****************************************
	// local constants
	// ****************************************
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_CONV = 2'h1;
	localparam [1:0] ST_COMP = 2'h2;
	localparam [31:0] CMP_LAST = COMPARE_CYCLES - 1;
	localparam [31:0] UNIT_LAST = PULSE_UNIT_CYCLES - 1;

	// ****************************************
	// declarations
	// ****************************************
	reg [`MPS_CTRL_WIDTH-1:0] ctrl_reg;
	reg [`MPS_ST_WIDTH-1:0] status_reg;
	reg [`MPS_ST_WIDTH-1:0] status_next;
	reg [`MPS_ST_WIDTH-1:0] mask_reg;
	reg [31:0] nominal_reg;
	reg nom_set_reg;
	reg [15:0] pulse_reg;
	reg [31:0] lim_lo [0:3];
	reg [31:0] lim_hi [0:3];
	reg [127:0] value_reg;
	reg [1:0] state_reg;
	reg [31:0] cnt_reg;
	reg [31:0] unit_reg;
	reg [15:0] pulse_left_reg;
	reg pulse_on_reg;
	reg trig_meta_reg;
	reg trig_sync_reg;
	reg trig_prev_reg;
	reg [3:0] result_reg;
	wire [1:0] beh;
	wire abs_mode;
	wire aux_en;
	wire comp_en;
	wire [1:0] cnt_sel;
	wire trig_fall;
	wire cmp_end;
	wire [3:0] oor;
	wire any_fail;
	wire aux_case;
	wire nom_missing;
	wire [`MPS_ST_WIDTH-1:0] events;
	wire lim_hit;
	wire [1:0] lim_idx;
	wire [31:0] st_word;
	reg [31:0] rd_next;
	integer k;

	assign beh = ctrl_reg[`MPS_CTRL_BEH_MSB:`MPS_CTRL_BEH_LSB];
	assign abs_mode = ctrl_reg[`MPS_CTRL_ABS_BIT];
	assign aux_en = ctrl_reg[`MPS_CTRL_AUX_BIT];
	assign comp_en = ctrl_reg[`MPS_CTRL_COMP_BIT];
	assign cnt_sel = ctrl_reg[`MPS_CTRL_CNT_MSB:`MPS_CTRL_CNT_LSB];
	assign lim_hit = reg_addr[`MPS_LIM_SEL_MSB:`MPS_LIM_SEL_LSB] ==
		`MPS_LIM_SEL_VAL;
	assign lim_idx = reg_addr[`MPS_LIM_IDX_MSB:`MPS_LIM_IDX_LSB];

	// ****************************************
	// trigger pin synchroniser and edge
	// ****************************************
	// two flops before the edge detector reads the pin
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			trig_meta_reg <= 1'b1;
			trig_sync_reg <= 1'b1;
			trig_prev_reg <= 1'b1;
		end else begin
			trig_meta_reg <= handler_trigger_n;
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
		end
	end
	assign trig_fall = trig_prev_reg & ~trig_sync_reg;

	// ****************************************
	// limit comparison, one lane per parameter
	// ****************************************
	// lane one compares its deviation from nominal in deviation mode
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_cmp
			wire [31:0] raw = value_reg[32*g+:32];
			wire [31:0] dev = (g == 0 && !abs_mode) ?
				raw - nominal_reg : raw; // [RULE6]
			wire used = (g <= cnt_sel) && comp_en;
			assign oor[g] = used &&
				(($signed(dev) < $signed(lim_lo[g])) ||
				($signed(dev) > $signed(lim_hi[g])) ||
				(g == 0 && nom_missing)); // [RULE7]
		end
	endgenerate
	// comparing without a nominal is meaningless, so it counts as failing
	assign nom_missing = !abs_mode && !nom_set_reg; // [RULE6]
	assign any_fail = |oor; // [RULE1]
	assign aux_case = aux_en && (oor == 4'h2); // [RULE5]

	// ****************************************
	// measurement sequence
	// ****************************************
	assign cmp_end = (state_reg == ST_COMP) && (cnt_reg == CMP_LAST);

	// trigger starts a conversion; compare time runs after adc_done
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 32'h00000000;
			value_reg <= 128'h0;
			meas_start <= 1'b0;
			conversion_done_n <= 1'b1;
			measurement_done_n <= 1'b1;
		end else begin
			meas_start <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (trig_fall) begin
					meas_start <= 1'b1;
					conversion_done_n <= 1'b1;
					measurement_done_n <= 1'b1;
					state_reg <= ST_CONV;
				end
			end
			ST_CONV: begin
				if (adc_done) begin
					value_reg <= {param_four_value, param_three_value,
						param_two_value, param_one_value};
					conversion_done_n <= 1'b0; // [RULE2]
					cnt_reg <= 32'h00000000;
					state_reg <= ST_COMP;
				end
			end
			ST_COMP: begin
				cnt_reg <= cnt_reg + 32'h00000001; // [RULE9]
				if (cmp_end) begin
					measurement_done_n <= 1'b0; // [RULE3]
					state_reg <= ST_IDLE;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// sorting port lines
	// ****************************************
	// results update together with measurement-done, never before
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			result_reg <= 4'h0;
			param_one_fail_n <= 1'b1;
			param_two_fail_n <= 1'b1;
			param_three_fail_n <= 1'b1;
			param_four_fail_n <= 1'b1;
			fail_n <= 1'b1;
			aux_bin_n <= 1'b1;
			pulse_on_reg <= 1'b0;
			pulse_left_reg <= 16'h0000;
			unit_reg <= 32'h00000000;
		end else if (cmp_end) begin
			result_reg <= {aux_case, any_fail & ~aux_case, oor[1], oor[0]};
			param_one_fail_n <= ~oor[0]; // [RULE7] [RULE8]
			param_two_fail_n <= ~oor[1]; // [RULE7]
			param_three_fail_n <= ~oor[2]; // [RULE7]
			param_four_fail_n <= ~oor[3]; // [RULE7]
			fail_n <= ~(any_fail & ~aux_case); // [RULE1] [RULE5]
			aux_bin_n <= ~aux_case; // [RULE5]
			pulse_on_reg <= (beh == `MPS_BEH_PULSE); // [RULE4]
			pulse_left_reg <= (pulse_reg == 16'h0000) ? 16'h0001 : pulse_reg;
			unit_reg <= 32'h00000000;
		end else if (trig_fall && state_reg == ST_IDLE &&
			beh == `MPS_BEH_CLEAR) begin
			// clear mode drops the lines at every new start
			param_one_fail_n <= 1'b1; // [RULE4]
			param_two_fail_n <= 1'b1;
			param_three_fail_n <= 1'b1;
			param_four_fail_n <= 1'b1;
			fail_n <= 1'b1;
			aux_bin_n <= 1'b1;
			pulse_on_reg <= 1'b0;
		end else if (pulse_on_reg) begin
			// pulse mode releases the lines after the set width in units
			if (unit_reg == UNIT_LAST) begin
				unit_reg <= 32'h00000000;
				pulse_left_reg <= pulse_left_reg - 16'h0001;
				if (pulse_left_reg == 16'h0001) begin
					pulse_on_reg <= 1'b0;
					param_one_fail_n <= 1'b1; // [RULE4]
					param_two_fail_n <= 1'b1;
					param_three_fail_n <= 1'b1;
					param_four_fail_n <= 1'b1;
					fail_n <= 1'b1;
					aux_bin_n <= 1'b1;
				end
			end else begin
				unit_reg <= unit_reg + 32'h00000001;
			end
		end
	end

	// ****************************************
	// register writes and interrupt
	// ****************************************
	assign events = {cmp_end & nom_missing, cmp_end & any_fail & ~aux_case,
		cmp_end, state_reg == ST_CONV && adc_done};

	// new events win over a write-one-to-clear in the same cycle
	always @* begin
		status_next = status_reg;
		if (reg_wr && reg_addr == `MPS_ADDR_STATUS)
			status_next = status_reg & ~reg_wdata[`MPS_ST_WIDTH-1:0];
		status_next = status_next | events;
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `MPS_CTRL_RESET;
			status_reg <= 4'h0;
			mask_reg <= 4'h0;
			nominal_reg <= 32'h00000000;
			nom_set_reg <= 1'b0;
			pulse_reg <= `MPS_PULSE_RESET;
			irq <= 1'b0;
			for (k = 0; k < 4; k = k + 1) begin
				lim_lo[k] <= 32'h00000000;
				lim_hi[k] <= 32'h00000000;
			end
		end else begin
			status_reg <= status_next;
			irq <= |(status_next & mask_reg);
			if (reg_wr) begin
				if (reg_addr == `MPS_ADDR_CTRL)
					ctrl_reg <= reg_wdata[`MPS_CTRL_WIDTH-1:0];
				if (reg_addr == `MPS_ADDR_MASK)
					mask_reg <= reg_wdata[`MPS_ST_WIDTH-1:0];
				if (reg_addr == `MPS_ADDR_NOMINAL) begin
					nominal_reg <= reg_wdata;
					nom_set_reg <= 1'b1; // [RULE6]
				end
				if (reg_addr == `MPS_ADDR_PULSE)
					pulse_reg <= reg_wdata[15:0];
				if (lim_hit && reg_addr[`MPS_LIM_HI_BIT])
					lim_hi[lim_idx] <= reg_wdata;
				if (lim_hit && !reg_addr[`MPS_LIM_HI_BIT])
					lim_lo[lim_idx] <= reg_wdata;
			end
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	assign st_word = {24'h0, nom_set_reg, ~measurement_done_n,
		~conversion_done_n, result_reg, state_reg != ST_IDLE};

	// data stand in the cycle after the read strobe only
	always @* begin
		rd_next = 32'h00000000;
		if (lim_hit && reg_addr[`MPS_LIM_HI_BIT])
			rd_next = lim_hi[lim_idx];
		else if (lim_hit)
			rd_next = lim_lo[lim_idx];
		else begin
			case (reg_addr)
			`MPS_ADDR_CTRL: rd_next = {25'h0, ctrl_reg};
			`MPS_ADDR_STATUS: rd_next = {28'h0, status_reg};
			`MPS_ADDR_MASK: rd_next = {28'h0, mask_reg};
			`MPS_ADDR_NOMINAL: rd_next = nominal_reg;
			`MPS_ADDR_PULSE: rd_next = {16'h0, pulse_reg};
			`MPS_ADDR_STATE: rd_next = st_word;
			default: rd_next = 32'h00000000;
			endcase
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
			reg_rdata <= rd_next;
		else
			reg_rdata <= 32'h00000000;
	end

endmodule // mps_handler_out

// ==== rtl/mps_regs.vh ====
// constants for the multi-parameter sort handler output block
// assumes a 250 MHz clock and a 32-bit register port with byte offsets
`ifndef MPS_REGS_VH
`define MPS_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define MPS_ADDR_CTRL 8'h00
`define MPS_ADDR_STATUS 8'h04
`define MPS_ADDR_MASK 8'h08
`define MPS_ADDR_NOMINAL 8'h0C
`define MPS_ADDR_PULSE 8'h10
`define MPS_ADDR_STATE 8'h14
// limit pairs: low at base + 8*i, high at base + 8*i + 4
`define MPS_LIM_SEL_MSB 7
`define MPS_LIM_SEL_LSB 5
`define MPS_LIM_SEL_VAL 3'h1
`define MPS_LIM_IDX_MSB 4
`define MPS_LIM_IDX_LSB 3
`define MPS_LIM_HI_BIT 2

// ****************************************
// control fields
// ****************************************
`define MPS_CTRL_BEH_MSB 1
`define MPS_CTRL_BEH_LSB 0
`define MPS_CTRL_ABS_BIT 2
`define MPS_CTRL_AUX_BIT 3
`define MPS_CTRL_COMP_BIT 4
`define MPS_CTRL_CNT_MSB 6
`define MPS_CTRL_CNT_LSB 5
`define MPS_CTRL_RESET 7'h74
`define MPS_CTRL_WIDTH 7
`define MPS_PULSE_RESET 16'h0001

// sort port behaviours
`define MPS_BEH_CLEAR 2'h0
`define MPS_BEH_HOLD 2'h1
`define MPS_BEH_PULSE 2'h2

// ****************************************
// status and interrupt bits
// ****************************************
`define MPS_ST_CONV 0
`define MPS_ST_MEAS 1
`define MPS_ST_FAIL 2
`define MPS_ST_NOM 3
`define MPS_ST_WIDTH 4

// ****************************************
// timing
// ****************************************
`define MPS_CLK_MHZ 250
`define MPS_COMPARE_TIME_US 4500
`define MPS_COMPARE_CYCLES (`MPS_COMPARE_TIME_US * `MPS_CLK_MHZ)
`define MPS_PULSE_UNIT_US 1000
`define MPS_PULSE_UNIT_CYCLES (`MPS_PULSE_UNIT_US * `MPS_CLK_MHZ)

`endif

// ==== bench/mps_handler_out_monitor.sv ====
// checker for the sort handler port outputs
// bound to mps_handler_out, sees its ports only
`timescale 1ns/1ps
module mps_handler_out_monitor #(
	parameter COMPARE_CYCLES = 20
) (
	input wire ref_clk,
	input wire rst,
	input wire meas_start,
	input wire adc_done,
	input wire param_one_fail_n,
	input wire param_two_fail_n,
	input wire param_three_fail_n,
	input wire param_four_fail_n,
	input wire fail_n,
	input wire aux_bin_n,
	input wire conversion_done_n,
	input wire measurement_done_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	reg [31:0] conv_cnt_reg;
	wire [3:0] lines_n = {param_one_fail_n, param_two_fail_n,
		param_three_fail_n, param_four_fail_n};
	// ****************************************
	// helper: cycles since conversion done fell
	// ****************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			conv_cnt_reg <= 32'h0;
		else if (conversion_done_n)
			conv_cnt_reg <= 32'h0;
		else
			conv_cnt_reg <= conv_cnt_reg + 32'h1;
	end
	// ****************************************
	// assertions
	// ****************************************
	a_fail_has_line: assert property (!fail_n |-> lines_n != 4'hF)
		else $error("fail line low with no parameter line low");
	a_conv_done_fast: assert property (adc_done |=> !conversion_done_n)
		else $error("conversion done late");
	a_compare_time: assert property (
		$fell(measurement_done_n) |-> conv_cnt_reg == COMPARE_CYCLES)
		else $error("compare time wrong");
	a_meas_after_conv: assert property (
		!measurement_done_n |-> !conversion_done_n)
		else $error("measurement done before conversion done");
	a_start_clears: assert property (
		meas_start |-> conversion_done_n && measurement_done_n)
		else $error("done strobes not cleared at start");
	a_fail_with_done: assert property (
		$fell(fail_n) |-> $fell(measurement_done_n))
		else $error("fail line changed outside result update");
	a_line_with_done: assert property (
		$fell(param_three_fail_n) |-> $fell(measurement_done_n))
		else $error("parameter line changed outside result update");
	a_aux_no_fail: assert property (
		!aux_bin_n |-> fail_n && !param_two_fail_n)
		else $error("aux bin with fail line");
	c_meas: cover property ($fell(measurement_done_n));
	c_aux: cover property (!aux_bin_n);
	c_fail: cover property (!fail_n);
endmodule // mps_handler_out_monitor

// ==== bench/mps_handler_model.sv ====
// handler and analog engine model at the far side of the sort port
// assumes it shares ref_clk with mps_handler_out
`timescale 1ns/1ps
module mps_handler_model #(
	parameter ENGINE_DELAY = 6
) (
	input wire ref_clk,
	input wire rst,
	input wire meas_start,
	input wire measurement_done_n,
	output reg handler_trigger_n,
	output reg adc_done,
	output wire [31:0] v1,
	output wire [31:0] v2,
	output wire [31:0] v3,
	output wire [31:0] v4
);
	reg [31:0] val_reg [0:3];
	reg [3:0] wait_reg;
	// values valid only with the conversion pulse, inverted otherwise
	assign v1 = adc_done ? val_reg[0] : ~val_reg[0];
	assign v2 = adc_done ? val_reg[1] : ~val_reg[1];
	assign v3 = adc_done ? val_reg[2] : ~val_reg[2];
	assign v4 = adc_done ? val_reg[3] : ~val_reg[3];
	initial begin
		handler_trigger_n = 1'b1;
	end
	// engine: conversion ends a fixed time after each start
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 4'h0;
			adc_done <= 1'b0;
		end else begin
			adc_done <= (wait_reg == 4'h1);
			if (meas_start)
				wait_reg <= ENGINE_DELAY[3:0];
			else if (wait_reg != 4'h0)
				wait_reg <= wait_reg - 4'h1;
		end
	end
	// one handler cycle: trigger, then wait for end of measurement
	task measure(input [31:0] a, input [31:0] b, input [31:0] c,
		input [31:0] d);
		integer n;
		begin
			val_reg[0] = a;
			val_reg[1] = b;
			val_reg[2] = c;
			val_reg[3] = d;
			handler_trigger_n <= 1'b0;
			repeat (8) @(posedge ref_clk);
			handler_trigger_n <= 1'b1;
			n = 0;
			while (measurement_done_n !== 1'b0 && n < 200) begin
				@(posedge ref_clk);
				n = n + 1;
			end
		end
	endtask
endmodule // mps_handler_model

// ==== bench/test_mps_handler_out.sv ====
// self-checking bench for the sort handler port outputs
// assumes mps_regs.vh on the include path
`timescale 1ns/1ps
`include "mps_regs.vh"
module test_mps_handler_out;
	reg ref_clk, rst, reg_wr, reg_rd;
	reg [7:0] reg_addr;
	reg [31:0] reg_wdata, rd_val;
	wire [31:0] reg_rdata, v1, v2, v3, v4;
	wire trig_n, start, adc, p1, p2, p3, p4, fl_n, aux_n, conv_n, meas_n, irq;
	wire [5:0] lines = {p1, p2, p3, p4, fl_n, aux_n};
	integer err_count, compares, cycles, i;
	mps_handler_out #(.COMPARE_CYCLES(20), .PULSE_UNIT_CYCLES(5)) uut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .handler_trigger_n(trig_n), .meas_start(start),
		.adc_done(adc), .param_one_value(v1), .param_two_value(v2),
		.param_three_value(v3), .param_four_value(v4),
		.param_one_fail_n(p1), .param_two_fail_n(p2),
		.param_three_fail_n(p3), .param_four_fail_n(p4), .fail_n(fl_n),
		.aux_bin_n(aux_n), .conversion_done_n(conv_n),
		.measurement_done_n(meas_n), .irq(irq));
	mps_handler_model ph (.ref_clk(ref_clk), .rst(rst), .meas_start(start),
		.measurement_done_n(meas_n), .handler_trigger_n(trig_n),
		.adc_done(adc), .v1(v1), .v2(v2), .v3(v3), .v4(v4));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task final_report;
		begin
			if (err_count == 0 && compares > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task check(input string what, input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	// ****************************************
	// register bus tasks
	// ****************************************
	task wr(input [7:0] a, input [31:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rd(input [7:0] a);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge ref_clk);
			reg_rd <= 1'b0;
			#1 rd_val = reg_rdata;
			@(posedge ref_clk);
		end
	endtask
	task rdc(input [7:0] a, input [31:0] e);
		begin
			rd(a);
			check("register", rd_val, e);
		end
	endtask
	// one measurement under a given control word
	task run(input [31:0] ctl, input [31:0] a, input [31:0] b,
		input [31:0] c, input [31:0] d, input [31:0] e);
		begin
			wr(`MPS_ADDR_CTRL, ctl);
			ph.measure(a, b, c, d);
			check("conversion done", 32'(conv_n), 32'h0);
			check("lines", 32'(lines), e);
		end
	endtask
	// hang guard
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			err_count = err_count + 1;
			final_report;
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		err_count = 0;
		compares = 0;
		cycles = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		check("idle lines", 32'(lines), 32'h3F);
		rdc(`MPS_ADDR_CTRL, 32'h74);
		rdc(`MPS_ADDR_PULSE, 32'h1);
		rdc(`MPS_ADDR_MASK, 32'h0);
		rdc(8'hFC, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'(8'h20 + 8 * i), 32'd10);
			wr(8'(8'h24 + 8 * i), 32'd20);
		end
		rdc(8'h3C, 32'd20);
		rdc(8'h38, 32'd10);
		run(32'h74, 15, 15, 15, 15, 32'h3F);
		run(32'h74, 15, 15, 21, 15, 32'h35);
		run(32'h74, 9, 25, 10, 20, 32'h0D);
		run(32'h7C, 15, 25, 15, 15, 32'h2E);
		rdc(`MPS_ADDR_STATE, 32'h74);
		run(32'h7C, 25, 25, 15, 15, 32'h0D);
		run(32'h70, 15, 15, 15, 15, 32'h1D);
		rd(`MPS_ADDR_STATUS);
		check("nominal flag", rd_val & 32'h8, 32'h8);
		wr(`MPS_ADDR_NOMINAL, 32'd100);
		run(32'h70, 115, 15, 15, 15, 32'h3F);
		run(32'h70, 15, 15, 15, 15, 32'h1D);
		rdc(`MPS_ADDR_STATE, 32'hEA);
		run(32'h64, 25, 25, 25, 25, 32'h3F);
		run(32'h34, 15, 15, 25, 25, 32'h3F);
		// clear then hold: lines during the next measurement
		for (i = 0; i < 2; i = i + 1) begin
			run(32'h74 | i, 25, 15, 15, 15, 32'h1D);
			fork
				ph.measure(15, 15, 15, 15);
				begin
					repeat (20) @(posedge ref_clk);
					check("busy done", 32'(meas_n), 32'h1);
					check("busy lines", 32'(lines), i ? 32'h1D : 32'h3F);
				end
			join
		end
		wr(`MPS_ADDR_PULSE, 32'h2);
		run(32'h76, 25, 15, 15, 15, 32'h1D);
		repeat (12) @(posedge ref_clk);
		check("pulse end", 32'(lines), 32'h3F);
		check("irq masked", 32'(irq), 32'h0);
		wr(`MPS_ADDR_MASK, 32'h2);
		@(posedge ref_clk);
		check("irq set", 32'(irq), 32'h1);
		wr(`MPS_ADDR_STATUS, 32'hF);
		@(posedge ref_clk);
		check("irq clear", 32'(irq), 32'h0);
		rdc(`MPS_ADDR_STATUS, 32'h0);
		final_report;
	end
endmodule // test_mps_handler_out
bind mps_handler_out mps_handler_out_monitor #(
	.COMPARE_CYCLES(COMPARE_CYCLES)) mon (.ref_clk(ref_clk), .rst(rst),
	.meas_start(meas_start), .adc_done(adc_done),
	.param_one_fail_n(param_one_fail_n), .param_two_fail_n(param_two_fail_n),
	.param_three_fail_n(param_three_fail_n),
	.param_four_fail_n(param_four_fail_n), .fail_n(fail_n),
	.aux_bin_n(aux_bin_n), .conversion_done_n(conversion_done_n),
	.measurement_done_n(measurement_done_n));
